// >>> bench/dct_link_properties.sv
// Concurrent checks on the command link between the two ends
`timescale 1ns/10ps
`default_nettype none
module dct_link_properties
   import dct_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Link signals
   input  wire dct_cmd_t    cmd,
   input  wire logic        cke,
   input  wire logic        odt,
   input  wire logic [12:0] addr,
   input  wire logic        wr_data_last,
   input  wire logic        strobe_diff,
   input  wire logic        odt_on,
   input  wire logic        odt_off_pend
);
   // ---------------------------------------------------------------
   // Link timing properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Two samples of a new termination level
   sequence s_odt_up;
      $rose(odt) ##1 odt;
   endsequence
   sequence s_odt_down;
      $fell(odt) ##1 !odt;
   endsequence

   AST_ODT_ON: assert property (s_odt_up |=> odt_on)
      else $error("termination not on after two edges");
   AST_ODT_OFF: assert property (s_odt_down |=> !odt_on)
      else $error("termination not off after two edges");
   // Tail marker may trail the fall by one cycle
   AST_OFF_TAIL: assert property ($fell(odt_on) |-> ##[0:1] odt_off_pend)
      else $error("termination tail marker missing");
   AST_STROBE: assert property (cmd == DCT_CMD_MRS |=> strobe_diff == !$past(addr[MR_STROBE_BIT]))
      else $error("strobe style does not follow mode bit");
   AST_MRS_GAP: assert property (cmd == DCT_CMD_MRS |=> cmd != DCT_CMD_MRS)
      else $error("mode sets too close");
   AST_CKE_HOLD: assert property ($changed(cke) |=> $stable(cke) [*2])
      else $error("clock enable changed too soon");
   AST_CKE_NOP: assert property (!cke |-> cmd == DCT_CMD_NOP)
      else $error("command issued with clock enable low");
   AST_WTR: assert property (wr_data_last |=> (cmd != DCT_CMD_RD) [*2])
      else $error("read too soon after write data");
   AST_RTP: assert property (cmd == DCT_CMD_RD |=> (cmd != DCT_CMD_PRE) [*2])
      else $error("precharge too soon after read");
   AST_XARD: assert property ($rose(cke) |=> (cmd != DCT_CMD_RD) [*3])
      else $error("read too soon after power-down exit");
endmodule : dct_link_properties
`default_nettype wire

// >>> bench/dram_command_timing_rules_test.sv
// Self-checking test of both link ends joined through the interface
`timescale 1ns/10ps
`default_nettype none
module dram_command_timing_rules_test;
   import dct_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus, design and checker
   // ---------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        req_valid = 1'b0;
   dct_cmd_t    req_cmd = DCT_CMD_NOP;
   logic [12:0] req_addr = 13'h0000;
   logic        req_cke = 1'b0;
   logic        req_odt = 1'b0;
   logic        req_wr_last = 1'b0;
   logic        cke_active;
   logic        pd_slow;
   logic        req_ready;
   logic [12:0] mode;
   logic [12:0] a;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   dct_cmd_t    exp_q[$];

   always #25 clk_i = ~clk_i;

   dct_if lnk();
   dct_ctrl #(.BURST_LENGTH(4)) dct_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_addr_i(req_addr),
      .req_cke_i(req_cke), .req_odt_i(req_odt), .req_wr_last_i(req_wr_last),
      .req_ready_o(req_ready), .lnk(lnk));
   dct_device dct_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk),
      .cke_active_o(cke_active), .pd_slow_exit_o(pd_slow), .mode_o(mode));
   dct_link_properties dct_link_properties_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .cmd(lnk.cmd), .cke(lnk.cke), .odt(lnk.odt), .addr(lnk.addr),
      .wr_data_last(lnk.wr_data_last), .strobe_diff(lnk.strobe_diff),
      .odt_on(lnk.odt_on), .odt_off_pend(lnk.odt_off_pend));

   task automatic cmp_val(input logic [12:0] got, input logic [12:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_val

   task automatic cmp_cmd(input dct_cmd_t got, input dct_cmd_t exp);
      cmp_val({10'h000, got}, {10'h000, exp});
   endtask : cmp_cmd

   task automatic tally_and_finish;
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Hold the offer until the command shows; the command stands one cycle only
   task automatic issue(input dct_cmd_t c, input logic [12:0] ad);
      exp_q.push_back(c);
      req_cmd = c;
      req_addr = ad;
      req_valid = 1'b1;
      do
      begin
         @(negedge clk_i);
      end while (lnk.cmd !== c);
      req_valid = 1'b0;
      @(negedge clk_i);
   endtask : issue

   // Level change rides on a NOP so no command shares the cycle
   task automatic set_cke(input logic v);
      req_cmd = DCT_CMD_NOP;
      req_valid = 1'b1;
      req_cke = v;
      while (lnk.cke !== v) @(negedge clk_i);
      req_valid = 1'b0;
      @(negedge clk_i);
   endtask : set_cke

   // Every command on the link must match the oldest note; also the hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         num_errors++;
         tally_and_finish();
      end
      else if (!sys_rst_i && lnk.cmd !== DCT_CMD_NOP)
      begin
         if (exp_q.size() == 0)
            cmp_cmd(lnk.cmd, DCT_CMD_NOP);
         else
            cmp_cmd(lnk.cmd, exp_q.pop_front());
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(32'hB6F6));
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      cmp_val(mode, MR_RESET);
      cmp_val({12'h000, lnk.strobe_diff}, 13'h0001);
      // A read offered with clock enable low must not appear
      req_cmd = DCT_CMD_RD;
      req_valid = 1'b1;
      repeat (4) @(negedge clk_i);
      cmp_cmd(lnk.cmd, DCT_CMD_NOP);
      set_cke(1'b1);
      @(negedge clk_i);
      cmp_val({12'h000, cke_active}, 13'h0000);
      @(negedge clk_i);
      cmp_val({12'h000, cke_active}, 13'h0001);
      // Back-to-back mode sets through all strobe and exit settings
      for (int i = 0; i < 4; i++)
      begin
         a = 13'($urandom());
         a[MR_STROBE_BIT] = i[0];
         a[MR_PDEXIT_BIT] = i[1];
         issue(DCT_CMD_MRS, a);
         cmp_val({12'h000, req_ready}, 13'h0000);
         @(negedge clk_i);
         cmp_val({12'h000, req_ready}, 13'h0001);
         cmp_val(mode, a);
         cmp_val({12'h000, lnk.strobe_diff}, {12'h000, ~a[MR_STROBE_BIT]});
         cmp_val({12'h000, pd_slow}, {12'h000, a[MR_PDEXIT_BIT]});
      end
      // Termination on and off, counted from the first registered level
      req_odt = 1'b1;
      while (lnk.odt !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
      cmp_val({12'h000, lnk.odt_on}, 13'h0000);
      @(negedge clk_i);
      cmp_val({12'h000, lnk.odt_on}, 13'h0001);
      req_odt = 1'b0;
      while (lnk.odt !== 1'b0) @(negedge clk_i);
      @(negedge clk_i);
      cmp_val({12'h000, lnk.odt_on}, 13'h0001);
      @(negedge clk_i);
      cmp_val({12'h000, lnk.odt_on}, 13'h0000);
      // Write then read at once, then precharge straight after the read
      issue(DCT_CMD_ACT, 13'($urandom()));
      issue(DCT_CMD_WR, 13'($urandom()));
      req_wr_last = 1'b1;
      @(negedge clk_i);
      req_wr_last = 1'b0;
      issue(DCT_CMD_RD, 13'($urandom()));
      issue(DCT_CMD_PRE, 13'($urandom()));
      // Power-down and an eager exit followed by a read
      set_cke(1'b0);
      set_cke(1'b1);
      issue(DCT_CMD_RD, 13'($urandom()));
      repeat (10) @(negedge clk_i);
      cmp_val(13'(exp_q.size()), 13'h0000);
      tally_and_finish();
   end
endmodule : dram_command_timing_rules_test
`default_nettype wire

// >>> verilog/dct_ctrl.sv
// Controller end: per-constraint counters gating each command
`timescale 1ns/10ps
`default_nettype none
module dct_ctrl
   import dct_pkg::*;
#(
   parameter int BURST_LENGTH = 4
)
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // User request
   input  wire logic         req_valid_i,
   input  wire dct_cmd_t     req_cmd_i,
   input  wire logic [12:0]  req_addr_i,
   input  wire logic         req_cke_i,
   input  wire logic         req_odt_i,
   input  wire logic         req_wr_last_i,
   output logic              req_ready_o,
   // Link
   dct_if.ctrl               lnk
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   // Spacing counters count down to zero; zero means the gap is met
   logic [CNT_W-1:0]   rtp_q, rtp_d;
   logic [CNT_W-1:0]   ras_q, ras_d;
   logic [CNT_W-1:0]   wtr_q, wtr_d;
   logic [CNT_W-1:0]   mrd_q, mrd_d;
   logic [CNT_W-1:0]   cke_q, cke_d;
   logic [CNT_W-1:0]   pdx_q, pdx_d;
   logic               ready_q, ready_d;
   // Shadow of the mode fields that the spacing depends on
   logic [MR_AL_W-1:0] al_q, al_d;
   logic               slow_q, slow_d;
   // Registered link drive
   dct_cmd_t           cmd_q, cmd_d;
   logic               cke_o_q, cke_o_d;
   logic               odt_q, odt_d;
   logic               wl_q, wl_d;
   logic [MR_W-1:0]    addr_q, addr_d;
   // Acceptance of the offered request in this cycle
   logic               ok;
   logic               take;
   logic               cke_chg;

   // Count down, holding at zero
   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      return (v == '0) ? v : v - 1'b1;
   endfunction : dec

   // ---------------------------------------------------------------
   // Acceptance
   // ---------------------------------------------------------------
   // A request is taken only when every counter for its command is zero
   always_comb
   begin
      cke_chg = (req_cke_i != cke_o_q);
      case (req_cmd_i)
         DCT_CMD_PRE: ok = (rtp_q == '0) && (ras_q == '0);
         DCT_CMD_RD:  ok = (wtr_q == '0) && (pdx_q == '0);
         DCT_CMD_MRS: ok = (mrd_q == '0);
         default:     ok = 1'b1;
      endcase
      // Frequency changes and refresh upkeep are left to the user side
      if (cke_chg)
         ok = ok && (cke_q == '0) && (req_cmd_i == DCT_CMD_NOP);
      // Nothing but NOP while the device sits in power-down
      if (!cke_o_q && !cke_chg && req_cmd_i != DCT_CMD_NOP)
         ok = 1'b0;
      // The device drops commands until it has registered the new level
      if (cke_q > CNT_W'(CKE_HOLD_CLKS) && req_cmd_i != DCT_CMD_NOP)
         ok = 1'b0;
      take = req_valid_i && ok;
   end

   // ---------------------------------------------------------------
   // Spacing counters
   // ---------------------------------------------------------------
   // Loaded on the taking edge so each count starts with its command
   always_comb
   begin
      rtp_d = dec(rtp_q);
      ras_d = dec(ras_q);
      wtr_d = dec(wtr_q);
      mrd_d = dec(mrd_q);
      cke_d = dec(cke_q);
      pdx_d = dec(pdx_q);
      if (take && cke_chg)
      begin
         cke_d = CNT_W'(CKE_REG_EDGES + CKE_HOLD_CLKS);
         // Leaving power-down: a read waits for the chosen exit delay
         if (req_cke_i)
            pdx_d = slow_q
               ? CNT_W'(SLOW_PDX_RD_BASE + CKE_REG_EDGES) - CNT_W'(al_q)
               : CNT_W'(FAST_PDX_RD_CLKS + CKE_REG_EDGES);
      end
      if (take)
      begin
         case (req_cmd_i)
            DCT_CMD_ACT: ras_d = CNT_W'(RAS_CLKS);
            DCT_CMD_RD:  rtp_d = CNT_W'(al_q) + CNT_W'(BURST_LENGTH / 2)
                                 + CNT_W'(RTP_CLKS);
            DCT_CMD_MRS: mrd_d = CNT_W'(MRD_CLKS);
            default:     ;
         endcase
      end
      // One extra count covers the marker's trip through the link flop
      if (req_wr_last_i)
         wtr_d = CNT_W'(WTR_CLKS + 1);
      // Hint mirrors the clock enable and mode set counters as they will stand after this edge
      ready_d = (cke_d == '0) && (mrd_d == '0);
   end

   // Counters clear in reset so the first request is not held off
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rtp_q   <= '0;
         ras_q   <= '0;
         wtr_q   <= '0;
         mrd_q   <= '0;
         cke_q   <= '0;
         pdx_q   <= '0;
         ready_q <= 1'b0;
      end
      else
      begin
         rtp_q   <= rtp_d;
         ras_q   <= ras_d;
         wtr_q   <= wtr_d;
         mrd_q   <= mrd_d;
         cke_q   <= cke_d;
         pdx_q   <= pdx_d;
         ready_q <= ready_d;
      end
   end

   // ---------------------------------------------------------------
   // Mode shadow
   // ---------------------------------------------------------------
   // Keep the latency and exit speed that the device was last given
   always_comb
   begin
      al_d   = al_q;
      slow_d = slow_q;
      if (take && req_cmd_i == DCT_CMD_MRS)
      begin
         al_d   = req_addr_i[MR_AL_LSB +: MR_AL_W];
         slow_d = req_addr_i[MR_PDEXIT_BIT];
      end
   end

   // Shadow starts where the device's mode register starts
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         al_q   <= MR_RESET[MR_AL_LSB +: MR_AL_W];
         slow_q <= MR_RESET[MR_PDEXIT_BIT];
      end
      else
      begin
         al_q   <= al_d;
         slow_q <= slow_d;
      end
   end

   // ---------------------------------------------------------------
   // Link drive
   // ---------------------------------------------------------------
   // A command stands one cycle; levels stand until changed
   always_comb
   begin
      cmd_d   = DCT_CMD_NOP;
      cke_o_d = cke_o_q;
      odt_d   = req_odt_i;
      wl_d    = req_wr_last_i;
      addr_d  = addr_q;
      if (take)
      begin
         cmd_d  = req_cmd_i;
         addr_d = req_addr_i;
         if (cke_chg)
            cke_o_d = req_cke_i;
      end
   end

   // Link idles with clock enable low and no command
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         cmd_q   <= DCT_CMD_NOP;
         cke_o_q <= 1'b0;
         odt_q   <= 1'b0;
         addr_q  <= '0;
         wl_q    <= 1'b0;
      end
      else
      begin
         cmd_q   <= cmd_d;
         cke_o_q <= cke_o_d;
         odt_q   <= odt_d;
         addr_q  <= addr_d;
         wl_q    <= wl_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Link and ready straight from flops
   assign lnk.cmd          = cmd_q;
   assign lnk.cke          = cke_o_q;
   assign lnk.odt          = odt_q;
   assign lnk.addr         = addr_q;
   assign lnk.wr_data_last = wl_q;
   assign req_ready_o      = ready_q;

endmodule : dct_ctrl
`default_nettype wire

// >>> verilog/dct_device.sv
// Memory device end: clock enable registration, mode register, termination
`timescale 1ns/10ps
`default_nettype none
module dct_device
   import dct_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // Link
   dct_if.dev                lnk,
   // Status to user side
   output logic              cke_active_o,
   output logic              pd_slow_exit_o,
   output logic [MR_W-1:0]   mode_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [1:0]      cke_cnt_q, cke_cnt_d;
   logic            cke_act_q, cke_act_d;
   logic [MR_W-1:0] mr_q, mr_d;
   logic [1:0]      on_cnt_q, on_cnt_d;
   logic [1:0]      off_cnt_q, off_cnt_d;
   logic            odt_on_q, odt_on_d;
   logic            odt_pend_q, odt_pend_d;

   // Next state: clock enable needs a run of equal samples
   always_comb
   begin
      cke_cnt_d  = cke_cnt_q;
      cke_act_d  = cke_act_q;
      mr_d       = mr_q;
      on_cnt_d   = on_cnt_q;
      off_cnt_d  = off_cnt_q;
      odt_on_d   = odt_on_q;
      odt_pend_d = 1'b0;
      if (lnk.cke == cke_act_q)
         cke_cnt_d = '0;
      else if (cke_cnt_q == 2'(CKE_REG_EDGES - 1))
      begin
         cke_act_d = lnk.cke;
         cke_cnt_d = '0;
      end
      else
         cke_cnt_d = cke_cnt_q + 2'd1;
      // Mode register set; postamble length is never checked here
      if (cke_act_q && lnk.cmd == DCT_CMD_MRS)
         mr_d = lnk.addr;
      // Termination: on two edges after first high, off after two trailing
      if (lnk.odt && !odt_on_q)
      begin
         off_cnt_d = '0;
         if (on_cnt_q == 2'(ODT_ON_CLKS - 1))
         begin
            odt_on_d = 1'b1;
            on_cnt_d = '0;
         end
         else
            on_cnt_d = on_cnt_q + 2'd1;
      end
      else if (!lnk.odt && odt_on_q)
      begin
         on_cnt_d = '0;
         if (off_cnt_q == 2'(ODT_OFF_CLKS - 1))
         begin
            odt_on_d   = 1'b0;
            odt_pend_d = 1'b1;                             // One-cycle tail
            off_cnt_d  = '0;
         end
         else
            off_cnt_d = off_cnt_q + 2'd1;
      end
      else
      begin
         on_cnt_d  = '0;
         off_cnt_d = '0;
      end
   end

   // Registers
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         cke_cnt_q  <= '0;
         cke_act_q  <= 1'b0;
         mr_q       <= MR_RESET;
         on_cnt_q   <= '0;
         off_cnt_q  <= '0;
         odt_on_q   <= 1'b0;
         odt_pend_q <= 1'b0;
      end
      else
      begin
         cke_cnt_q  <= cke_cnt_d;
         cke_act_q  <= cke_act_d;
         mr_q       <= mr_d;
         on_cnt_q   <= on_cnt_d;
         off_cnt_q  <= off_cnt_d;
         odt_on_q   <= odt_on_d;
         odt_pend_q <= odt_pend_d;
      end
   end

   // Outputs straight from flops
   assign lnk.strobe_diff  = ~mr_q[MR_STROBE_BIT];
   assign lnk.odt_on       = odt_on_q;
   assign lnk.odt_off_pend = odt_pend_q;
   assign cke_active_o     = cke_act_q;
   assign pd_slow_exit_o   = mr_q[MR_PDEXIT_BIT];
   assign mode_o           = mr_q;

endmodule : dct_device
`default_nettype wire

// >>> verilog/dct_if.sv
// Interface: command link between controller and memory device
`timescale 1ns/10ps
`default_nettype none
interface dct_if;
   import dct_pkg::*;
   dct_cmd_t          cmd;
   logic              cke;
   logic              odt;
   logic [12:0]       addr;
   logic              wr_data_last;
   logic              strobe_diff;
   logic              odt_on;
   logic              odt_off_pend;

   modport ctrl (output cmd, output cke, output odt, output addr, output wr_data_last);
   modport dev  (input cmd, input cke, input odt, input addr, input wr_data_last,
                 output strobe_diff, output odt_on, output odt_off_pend);
endinterface : dct_if
`default_nettype wire

// >>> verilog/dct_pkg.sv
// Package: shared constants and types for the command timing link
package dct_pkg;

   // ---------------------------------------------------------------
   // Clock and time conversion
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;

   // ---------------------------------------------------------------
   // Command encoding on the link
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      DCT_CMD_NOP,
      DCT_CMD_ACT,
      DCT_CMD_RD,
      DCT_CMD_WR,
      DCT_CMD_PRE,
      DCT_CMD_MRS,
      DCT_CMD_REF
   } dct_cmd_t;

   // ---------------------------------------------------------------
   // Mode register layout
   // ---------------------------------------------------------------
   localparam int          MR_W            = 13;
   localparam int          MR_STROBE_BIT   = 10;
   localparam int          MR_PDEXIT_BIT   = 12;
   localparam int          MR_AL_LSB       = 3;
   localparam int          MR_AL_W         = 3;
   localparam logic [12:0] MR_RESET        = 13'h0000;

   // ---------------------------------------------------------------
   // Cycle figures
   // ---------------------------------------------------------------
   localparam int CKE_REG_EDGES     = 3;
   localparam int CKE_HOLD_CLKS     = 2;
   localparam int WTR_CLKS          = 2;
   localparam int FAST_PDX_RD_CLKS  = 2;
   localparam int SLOW_PDX_RD_BASE  = 8;
   localparam int MRD_CLKS          = 2;
   localparam int ODT_ON_CLKS       = 2;
   localparam int ODT_OFF_CLKS      = 2;
   localparam int CNT_W             = 8;

   // Round a nanosecond figure up to whole cycles, never below one
   function automatic int ns_to_clk(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_clk

   localparam int RTP_NS   = 8;
   localparam int RAS_NS   = 45;
   localparam int RTP_CLKS = ns_to_clk(RTP_NS);
   localparam int RAS_CLKS = ns_to_clk(RAS_NS);

endpackage : dct_pkg
